// ### src/pag_map.svh
// register map, field masks, reset values and bus codes for the port A block
`ifndef PAG_MAP_SVH
`define PAG_MAP_SVH

`define PAG_OFF_LAT 8'h00
`define PAG_OFF_WPU 8'h04
`define PAG_OFF_IOC 8'h08
`define PAG_OFF_DIR 8'h0c
`define PAG_OFF_PORT 8'h10
`define PAG_OFF_CTRL 8'h14
`define PAG_OFF_STAT 8'h18
`define PAG_OFF_MASK 8'h1c

`define PAG_LAT_MASK 6'h37
`define PAG_ALL_MASK 6'h3f
`define PAG_DIR_FORCE 6'h08
`define PAG_PIN3 3

`define PAG_WPU_RST 6'h3f
`define PAG_IOC_RST 6'h00
`define PAG_LAT_RST 6'h00
`define PAG_DIR_RST 6'h3f

`define PAG_BIT_GPD 0
`define PAG_BIT_CHG 0

`define PAG_RESP_OKAY 2'h0
`define PAG_RESP_SLVERR 2'h2

`endif

// ### src/pag_pkg.sv
// types shared by the port A block
package pag_pkg;

  localparam int PINS = 6;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [PINS-1:0] lat;
    logic [PINS-1:0] wpu;
    logic [PINS-1:0] ioc;
    logic [PINS-1:0] dir;
    logic [PINS-1:0] last_read;
    logic gpd;
    logic chg_status;
    logic chg_mask;
  } pag_state_s;

endpackage

// ### src/pag_sync.sv
// two-flop synchroniser for the asynchronous pin levels
`timescale 1ns/1ps
module pag_sync #(
  parameter int W = 6
) (
  // clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // both stages live in one state word
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } pag_sync_s;

  pag_sync_s r;
  pag_sync_s next_r;

  always_comb begin
    next_r.meta = d;
    next_r.q = r.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // only the second stage leaves, the first may still be settling
  assign q = r.q;

endmodule

// ### src/pag_port_a.sv
// port A: latch, direction, pull-ups, change interrupt, AXI4-Lite registers
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "pag_map.svh"
module pag_port_a (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // alternate functions sharing the pins
  input wire logic [5:0] alt_sel,
  input wire logic [5:0] alt_oe,
  input wire logic [5:0] alt_out,
  // pins
  input wire logic [5:0] pin_i,
  output logic [5:0] pin_o,
  output logic [5:0] pin_oe,
  output logic [5:0] pullup_en,
  // interrupt
  output logic irq
);

  pag_pkg::pag_state_s q;
  pag_pkg::pag_state_s next_q;

  logic [5:0] pin_level_bits;
  logic [5:0] drive_en;
  logic [5:0] input_mask;
  logic [5:0] mismatch_bits;
  logic change_seen;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic wr_hit;
  logic port_touch;
  logic stat_read;
  logic [5:0] wbyte;
  logic [31:0] rd_value;
  logic rd_hit;

  pag_sync #(
    .W(pag_pkg::PINS)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d(pin_i),
    .q(pin_level_bits)
  );

  // pin direction and drive
  always_comb begin
    // alternate function takes over the direction bit, except on pin 3, which always stays an input
    drive_en = (alt_sel & alt_oe) | (~alt_sel & ~q.dir);
    drive_en[`PAG_PIN3] = 1'b0;
  end

  assign pin_oe = drive_en;
  assign pin_o = (alt_sel & alt_out) | (~alt_sel & q.lat);
  // pull-up only on inputs and only while not globally disabled
  assign pullup_en = q.wpu & ~drive_en & {6{~q.gpd}};
  assign input_mask = ~drive_en;

  // outputs driving pins are excluded from the comparison
  assign mismatch_bits = q.ioc & input_mask & (pin_level_bits ^ q.last_read);
  assign change_seen = |mismatch_bits;

  // bus handshakes; a stopped block offers and takes nothing, so no beat is lost
  assign awready = ce & ~q.aw_held & ~q.bvalid;
  assign wready = ce & ~q.w_held & ~q.bvalid;
  assign arready = ce & ~q.rvalid;
  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign ar_take = arvalid & arready;
  assign do_write = q.aw_held & q.w_held & ~q.bvalid;
  assign wbyte = q.w_data[5:0];

  assign bvalid = ce & q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = ce & q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign irq = q.chg_status & q.chg_mask;

  // read mux
  always_comb begin
    rd_value = 32'h0;
    rd_hit = 1'b1;
    case (araddr)
      `PAG_OFF_LAT: rd_value[5:0] = q.lat & `PAG_LAT_MASK;
      `PAG_OFF_WPU: rd_value[5:0] = q.wpu;
      `PAG_OFF_IOC: rd_value[5:0] = q.ioc;
      `PAG_OFF_DIR: rd_value[5:0] = q.dir | `PAG_DIR_FORCE;
      `PAG_OFF_PORT: rd_value[5:0] = pin_level_bits;
      `PAG_OFF_CTRL: rd_value[`PAG_BIT_GPD] = q.gpd;
      `PAG_OFF_STAT: rd_value[`PAG_BIT_CHG] = q.chg_status;
      `PAG_OFF_MASK: rd_value[`PAG_BIT_CHG] = q.chg_mask;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    wr_hit = 1'b1;
    case (q.aw_addr)
      `PAG_OFF_LAT, `PAG_OFF_WPU, `PAG_OFF_IOC, `PAG_OFF_DIR,
      `PAG_OFF_PORT, `PAG_OFF_CTRL, `PAG_OFF_STAT, `PAG_OFF_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // any port access ends the mismatch condition
  assign port_touch = (ar_take & (araddr == `PAG_OFF_PORT)) |
                      (do_write & (q.aw_addr == `PAG_OFF_PORT));
  assign stat_read = ar_take & (araddr == `PAG_OFF_STAT);

  // next state
  always_comb begin
    next_q = q;
    if (aw_take) begin
      next_q.aw_held = 1'b1;
      next_q.aw_addr = awaddr;
    end
    if (w_take) begin
      next_q.w_held = 1'b1;
      next_q.w_data = wdata;
      next_q.w_strb = wstrb;
    end
    if (q.bvalid && bready) begin
      next_q.bvalid = 1'b0;
    end
    if (do_write) begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = wr_hit ? `PAG_RESP_OKAY : `PAG_RESP_SLVERR;
      // only the low byte holds fields
      if (q.w_strb[0]) begin
        case (q.aw_addr)
          `PAG_OFF_LAT, `PAG_OFF_PORT: next_q.lat = wbyte & `PAG_LAT_MASK;
          `PAG_OFF_WPU: next_q.wpu = wbyte & `PAG_ALL_MASK;
          `PAG_OFF_IOC: next_q.ioc = wbyte & `PAG_ALL_MASK;
          `PAG_OFF_DIR: next_q.dir = (wbyte & `PAG_LAT_MASK) | `PAG_DIR_FORCE;
          `PAG_OFF_CTRL: next_q.gpd = wbyte[`PAG_BIT_GPD];
          `PAG_OFF_MASK: next_q.chg_mask = wbyte[`PAG_BIT_CHG];
          default: next_q.gpd = q.gpd;
        endcase
      end
    end
    if (q.rvalid && rready) begin
      next_q.rvalid = 1'b0;
    end
    if (ar_take) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = rd_value;
      next_q.rresp = rd_hit ? `PAG_RESP_OKAY : `PAG_RESP_SLVERR;
    end
    if (port_touch) begin
      next_q.last_read = pin_level_bits;
    end
    // a standing mismatch wins over the clear-on-read
    next_q.chg_status = (q.chg_status & ~stat_read) | change_seen;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.lat <= `PAG_LAT_RST;
      q.wpu <= `PAG_WPU_RST;
      q.ioc <= `PAG_IOC_RST;
      q.dir <= `PAG_DIR_RST;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_lat_zero_bits: assert property (
    ce && ar_take && araddr == `PAG_OFF_LAT |=> rdata[7:6] == 2'h0 && rdata[3] == 1'b0)
    else $error("latch read shows unimplemented bits");

  chk_pin3_input: assert property (pin_oe[`PAG_PIN3] == 1'b0)
    else $error("pin 3 is driven");

  chk_drive_latch: assert property (
    ((pin_oe & ~alt_sel) == (~q.dir & ~alt_sel & `PAG_LAT_MASK)) &&
    ((pin_o & ~alt_sel) == (q.lat & ~alt_sel)))
    else $error("driver or data does not follow direction and latch");

  chk_alt_override: assert property (
    ((pin_oe & alt_sel) == (alt_oe & alt_sel & `PAG_LAT_MASK)))
    else $error("alternate function does not own the direction");

  chk_pullup_output: assert property ((pullup_en & pin_oe) == 6'h0)
    else $error("pull-up on while driving");

  chk_pullup_global: assert property (q.gpd |-> pullup_en == 6'h0)
    else $error("pull-up on while globally disabled");

  chk_pullup_input: assert property (
    !q.gpd |-> (pullup_en == (q.wpu & ~pin_oe)))
    else $error("input pin lost its enabled pull-up");

  chk_reset_values: assert property (
    $past(!aresetn) |-> q.wpu == `PAG_WPU_RST && q.ioc == `PAG_IOC_RST)
    else $error("enable bits wrong after reset");

  chk_change_flag: assert property (
    ce && change_seen |=> q.chg_status ##1 !ce || q.chg_status || !$past(change_seen))
    else $error("mismatch did not set the change flag");

  chk_port_read: assert property (
    ce && ar_take && araddr == `PAG_OFF_PORT |=> rdata[5:0] == $past(pin_level_bits))
    else $error("port read does not show pin levels");

  chk_lat_write: assert property (
    ce && do_write && q.w_strb[0] && q.aw_addr == `PAG_OFF_LAT
    |=> q.lat == ($past(wbyte) & `PAG_LAT_MASK))
    else $error("latch write not stored");

  chk_irq_level: assert property (q.chg_status && q.chg_mask |-> irq)
    else $error("unmasked flag without interrupt");

  chk_irq_mask: assert property (!q.chg_mask |-> !irq)
    else $error("masked flag raised the interrupt");

  chk_wpu_write: assert property (
    ce && do_write && q.w_strb[0] && q.aw_addr == `PAG_OFF_WPU
    |=> q.wpu == ($past(wbyte) & `PAG_ALL_MASK))
    else $error("pull-up enable write not stored");

  chk_ioc_write: assert property (
    ce && do_write && q.w_strb[0] && q.aw_addr == `PAG_OFF_IOC
    |=> q.ioc == ($past(wbyte) & `PAG_ALL_MASK))
    else $error("change enable write not stored");

  chk_dir_write: assert property (
    ce && do_write && q.w_strb[0] && q.aw_addr == `PAG_OFF_DIR
    |=> (q.dir & `PAG_LAT_MASK) == ($past(wbyte) & `PAG_LAT_MASK) && q.dir[`PAG_PIN3])
    else $error("direction write lost or pin 3 lost its input bit");

  chk_dir_read: assert property (
    ce && ar_take && araddr == `PAG_OFF_DIR |=> rdata[`PAG_PIN3])
    else $error("pin 3 direction does not read as input");

  chk_gpd_write: assert property (
    ce && do_write && q.w_strb[0] && q.aw_addr == `PAG_OFF_CTRL
    |=> q.gpd == $past(wbyte[`PAG_BIT_GPD]))
    else $error("global pull-up disable write not stored");

  chk_port_write: assert property (
    ce && do_write && q.w_strb[0] && q.aw_addr == `PAG_OFF_PORT
    |=> q.lat == ($past(wbyte) & `PAG_LAT_MASK))
    else $error("port write did not reach the latch");

  // a cleared low strobe must leave every field alone
  chk_strobe_off: assert property (
    ce && do_write && !q.w_strb[0]
    |=> $stable(q.lat) && $stable(q.wpu) && $stable(q.ioc) && $stable(q.dir) &&
        $stable(q.gpd) && $stable(q.chg_mask))
    else $error("write with low strobe changed a field");

  chk_bad_write: assert property (
    ce && do_write && !wr_hit |=> bresp == `PAG_RESP_SLVERR)
    else $error("unmapped write not refused");

  chk_bad_read: assert property (
    ce && ar_take && !rd_hit |=> rresp == `PAG_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");

  chk_b_hold: assert property (
    ce && bvalid && !bready |=> q.bvalid && $stable(q.bresp))
    else $error("write response dropped before taken");

  chk_r_hold: assert property (
    ce && rvalid && !rready |=> q.rvalid && $stable(q.rdata) && $stable(q.rresp))
    else $error("read data dropped before taken");

  chk_aw_refused: assert property (q.bvalid |-> !awready && !wready)
    else $error("write accepted while a response waits");

  chk_ar_refused: assert property (q.rvalid |-> !arready)
    else $error("read accepted while read data waits");

  chk_write_answer: assert property (
    ce && do_write |=> q.bvalid && !q.aw_held && !q.w_held)
    else $error("write not answered in the next cycle");

  chk_output_excluded: assert property ((mismatch_bits & pin_oe) == 6'h0)
    else $error("driven pin takes part in the change compare");

  chk_port_snapshot: assert property (
    ce && port_touch |=> q.last_read == $past(pin_level_bits))
    else $error("port access did not refresh the last-read value");

  chk_stat_clear: assert property (
    ce && stat_read && !change_seen |=> !q.chg_status)
    else $error("status read did not clear the change flag");

  chk_flag_cause: assert property (
    ce && !q.chg_status && !change_seen |=> !q.chg_status)
    else $error("change flag set without a mismatch");

  // registers and flag must hold still while the block is stopped
  chk_ce_freeze: assert property (!ce |=> $stable(q))
    else $error("state moved while the clock enable was low");

  cov_write: cover property (ce && do_write && wr_hit);
  cov_read_port: cover property (ce && ar_take && araddr == `PAG_OFF_PORT);
  cov_irq_rise: cover property ($rose(irq));
  cov_alt_pin: cover property (|(alt_sel & alt_oe));
  cov_stat_clear: cover property (ce && stat_read && q.chg_status && !change_seen);

endmodule

// ### test/pag_port_a_tb.sv
// self-checking bench for the port A block
`timescale 1ns/1ps
`include "pag_map.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module pag_port_a_tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic ce = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic [5:0] alt_sel = 0, alt_oe = 0, alt_out = 0, pin_i = 0;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [5:0] pin_o, pin_oe, pullup_en;
  int fails = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'd53;
  logic [5:0] m_lat = 0, m_wpu = 6'h3f, m_ioc = 0, m_dir = 6'h37;
  logic m_gpd = 0;
  logic [31:0] rv;
  logic [1:0] rs;
  logic [7:0] offs [8] = '{`PAG_OFF_LAT, `PAG_OFF_WPU, `PAG_OFF_IOC, `PAG_OFF_DIR,
    `PAG_OFF_CTRL, `PAG_OFF_PORT, `PAG_OFF_STAT, `PAG_OFF_MASK};

  always #2.5 aclk = ~aclk;

  pag_port_a u_pag_port_a (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .alt_sel(alt_sel), .alt_oe(alt_oe), .alt_out(alt_out),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pullup_en(pullup_en), .irq(irq));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] m_read(int k);
    case (k)
      0: return {26'h0, m_lat & 6'h37};
      1: return {26'h0, m_wpu};
      2: return {26'h0, m_ioc};
      3: return {26'h0, m_dir | 6'h08};
      default: return {31'h0, m_gpd};
    endcase
  endfunction

  // a cleared byte-0 strobe leaves every field alone
  task automatic m_write(int k, logic [31:0] v, logic [3:0] s);
    if (s[0]) begin
      case (k)
        0, 5: m_lat = v[5:0];
        1: m_wpu = v[5:0];
        2: m_ioc = v[5:0];
        3: m_dir = v[5:0] & 6'h37;
        4: m_gpd = v[0];
        default: ;
      endcase
    end
  endtask

  // handshakes are judged on the falling edge, where every level has settled
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s, output logic [1:0] r);
    logic aw_go;
    logic w_go;
    logic b_go;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    b_go = 0;
    while (!b_go) begin
      @(negedge aclk);
      aw_go = awvalid & awready;
      w_go = wvalid & wready;
      b_go = bvalid;
      if (b_go) r = bresp;
      @(posedge aclk);
      if (aw_go) awvalid <= 0;
      if (w_go) wvalid <= 0;
    end
    bready <= 0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_go;
    logic r_go;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    r_go = 0;
    while (!r_go) begin
      @(negedge aclk);
      ar_go = arvalid & arready;
      r_go = rvalid;
      if (r_go) begin
        d = rdata;
        r = rresp;
      end
      @(posedge aclk);
      if (ar_go) arvalid <= 0;
    end
    rready <= 0;
  endtask

  task automatic wm(int k, logic [31:0] v);
    wr(offs[k], v, 4'hf, rs);
    m_write(k, v, 4'hf);
    `CHK("bresp", `PAG_RESP_OKAY, rs)
  endtask

  task automatic rx(int k, logic [31:0] e);
    rd(offs[k], rv, rs);
    `CHK("rdata", e, rv)
    `CHK("rresp", `PAG_RESP_OKAY, rs)
  endtask

  // pin drive only matters where the pin is driven
  task automatic chk_pins();
    logic [5:0] oe;
    @(negedge aclk);
    oe = ((alt_sel & alt_oe) | (~alt_sel & ~m_dir)) & 6'h37;
    `CHK("pin_oe", oe, pin_oe)
    `CHK("pin_o", oe & ((alt_sel & alt_out) | (~alt_sel & m_lat)), oe & pin_o)
    `CHK("pullup_en", m_gpd ? 6'h00 : m_wpu & ~oe, pullup_en)
    `CHK("irq", 1'b0, irq)
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #50000;
    fails++;
    finish_test();
  end

  initial begin
    int k;
    logic [31:0] v;
    logic [3:0] s;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    for (int j = 0; j < 5; j++) rx(j, m_read(j));
    chk_pins();
    for (int i = 0; i < 24; i++) begin
      v = xs();
      alt_sel <= v[5:0];
      alt_oe <= v[11:6];
      alt_out <= v[17:12];
      pin_i <= v[23:18];
      k = int'(v[31:29]) % 5;
      s = v[28] ? 4'hf : 4'he;
      v = xs();
      wr(offs[k], v, s, rs);
      m_write(k, v, s);
      `CHK("bresp", `PAG_RESP_OKAY, rs)
      for (int j = 0; j < 5; j++) rx(j, m_read(j));
      chk_pins();
    end
    alt_sel <= 0;
    pin_i <= 6'h15;
    wm(3, 32'h3f);
    wm(2, 32'h3f);
    wm(7, 32'h1);
    repeat (3) @(posedge aclk);
    rx(5, 32'h15);
    rd(offs[6], rv, rs);
    rx(6, 32'h0);
    pin_i <= 6'h1d;
    repeat (4) @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    rx(6, 32'h1);
    rx(5, 32'h1d);
    rx(6, 32'h1);
    rx(6, 32'h0);
    // pin 0 turned to output must drop out of the change compare
    wm(5, 32'h2a);
    wm(3, 32'h3e);
    pin_i <= 6'h1c;
    repeat (4) @(posedge aclk);
    rx(6, 32'h0);
    rx(0, 32'h22);
    chk_pins();
    rx(7, 32'h1);
    // a write to the status register is ignored
    wm(6, 32'h1);
    rx(6, 32'h0);
    // a stopped block neither samples pins nor moves its flag
    ce <= 0;
    pin_i <= 6'h3c;
    repeat (6) @(posedge aclk);
    `CHK("irq", 1'b0, irq)
    ce <= 1;
    repeat (4) @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    rx(5, 32'h3c);
    rx(6, 32'h1);
    rx(6, 32'h0);
    wr(8'h20, 32'h1, 4'hf, rs);
    `CHK("bresp", `PAG_RESP_SLVERR, rs)
    rd(8'h20, rv, rs);
    `CHK("rresp", `PAG_RESP_SLVERR, rs)
    finish_test();
  end
endmodule
